// ---- core/pmcs_pkg.sv ----
package pmcs_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CLK_MHZ         = 100;
	localparam int unsigned T_RESET_INIT_US = 2;
	localparam int unsigned T_INIT_MS       = 2000;
	localparam int unsigned US_PER_MS       = 1000;
	localparam int unsigned RESET_PULSE_CYC = T_RESET_INIT_US * CLK_MHZ;
	localparam int unsigned T_INIT_CYC      = T_INIT_MS * US_PER_MS * CLK_MHZ;
	localparam int          CNT_W           = 28;
	localparam int          RCNT_W          = 8;

	// ************************************************************
	// Register bus map (word index)
	// ************************************************************
	localparam int          AV_AW      = 4;
	localparam int          AV_DW      = 32;
	localparam logic [3:0]  REG_COND   = 4'h0;
	localparam logic [3:0]  REG_STATUS = 4'h1;

	// ************************************************************
	// Serial management map
	// ************************************************************
	localparam logic [6:0]  DEV_ADDR    = 7'h50;
	localparam logic [7:0]  PTR_STATUS  = 8'h02;
	localparam logic [7:0]  PTR_FLAGS   = 8'h03;
	localparam logic [7:0]  PTR_MASK    = 8'h04;
	localparam logic [7:0]  PTR_CTRL    = 8'h05;
	localparam logic [7:0]  PTR_RST     = 8'h00;
	localparam int          NFLAG       = 3;
	localparam int          FLAG_RX_LOS = 0;
	localparam int          FLAG_TX_FLT = 1;
	localparam int          FLAG_OTHER  = 2;
	localparam int          BIT_NRDY    = 0;
	localparam int          BIT_PDOWN   = 0;
	localparam logic [2:0]  MASK_RST    = 3'h0;
	localparam logic [3:0]  BITS_BYTE   = 4'h8;
	localparam logic [3:0]  LAST_BIT    = 4'h7;

	// Synchroniser order: scl, sda, select_n, reset pin, low power
	localparam int          NSYNC    = 5;
	localparam logic [4:0]  SYNC_RST = 5'h1E;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		PM_RUN  = 3'b001,
		PM_BOOT = 3'b010,
		PM_HELD = 3'b100
	} pmcs_pm_e;

	typedef enum logic [6:0] {
		SER_IDLE    = 7'b0000001,
		SER_ADDR    = 7'b0000010,
		SER_ADDR_AK = 7'b0000100,
		SER_WR      = 7'b0001000,
		SER_WR_AK   = 7'b0010000,
		SER_RD      = 7'b0100000,
		SER_RD_AK   = 7'b1000000
	} pmcs_ser_e;

	typedef struct packed {
		logic scl;
		logic sda;
		logic sel_n;
		logic rst_n;
		logic lp;
	} pmcs_pins_s;

	typedef struct packed {
		pmcs_pm_e           pm;
		logic [CNT_W-1:0]   init_cnt;
		logic [RCNT_W-1:0]  rst_cnt;
		logic               not_ready;
		logic               done;
		logic [NFLAG-1:0]   cond;
		logic [NFLAG-1:0]   flags;
		logic [NFLAG-1:0]   mask;
		logic               pdown;
		logic               irq;
		logic               lowpwr;
		pmcs_ser_e          ser;
		logic [3:0]         bitcnt;
		logic [7:0]         shreg;
		logic [7:0]         ptr;
		logic               first_wr;
		logic               rd_dir;
		logic               mnack;
		logic               sda_drive;
		logic               scl_q;
		logic               sda_q;
		logic               av_ack;
		logic [AV_DW-1:0]   av_rdata;
	} pmcs_state_s;

	localparam pmcs_state_s STATE_RST = '{
		pm: PM_BOOT, init_cnt: '0, rst_cnt: '0, not_ready: 1'b1,
		done: 1'b0, cond: '0, flags: '0, mask: MASK_RST, pdown: 1'b0,
		irq: 1'b0, lowpwr: 1'b0, ser: SER_IDLE, bitcnt: '0, shreg: '0,
		ptr: PTR_RST, first_wr: 1'b0, rd_dir: 1'b0, mnack: 1'b0,
		sda_drive: 1'b0, scl_q: 1'b1, sda_q: 1'b1, av_ack: 1'b0,
		av_rdata: '0
	};

endpackage

// ---- core/pmcs_sync.sv ----
`timescale 1ns/1ps
module pmcs_sync #(
	parameter int                     W       = 1,
	parameter logic [W-1:0]           RST_VAL = '0
) (
	input  wire logic                 clock_i,
	input  wire logic                 reset_n_i,
	input  wire logic [W-1:0]         d_i,
	output logic      [W-1:0]         q_o
);

	// ************************************************************
	// Two flops; only the second stage is visible outside
	// ************************************************************
	logic [W-1:0] meta_r;

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			meta_r <= RST_VAL;
			q_o    <= RST_VAL;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end

endmodule

// ---- core/pmcs_core.sv ----
// Overview of operation
// - Serial bus answered only while module_select_n is low; else ignored.
// - Serial bus answers within 100 us after module_select_n falls.
// - Serial bus stops answering within 100 us after module_select_n rises.
// - Reset pin low over 2 us restores every user setting to default.
// - Module fully functional within 2000 ms of reset pin release.
// - Completion shown by interrupt_n asserted with monitor_data_pending clear.
// - Power-up posts completion interrupt without any reset pin pulse.
// - Fully functional within 2000 ms of power-on, hot plug or reset.
// - Serial bus answers within 2000 ms of power-on.
// - Within 2000 ms of power-on, pending bit clears, interrupt_n asserts.
// - low_power_request high drops power below 1 W within 100 us.
// - module_present_n is tied low inside the module.
// - interrupt_n is an open-drain low for faults or critical status.
// - interrupt_n goes low within 200 ms of a triggering condition.
// - Flags clear on read; interrupt_n releases within 500 us after.
// - Receive signal loss sets rx_signal_loss and interrupt within 100 ms.
// - Transmitter fault sets tx_failure_flag and interrupt within 200 ms.
// - Any other condition sets its flag and interrupt within 200 ms.
// - Setting a mask bit suppresses that flag's interrupt within 100 ms.
// - Clearing a mask bit restores that flag's interrupt within 100 ms.
// - Setting power_down_override enters low power within 100 ms.
// - Clearing power_down_override returns to full function within 300 ms.
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module pmcs_core #(
	parameter int unsigned                INIT_CYCLES = pmcs_pkg::T_INIT_CYC
) (
	input  wire logic                     clock_i,
	input  wire logic                     reset_n_i,
	input  wire logic [pmcs_pkg::AV_AW-1:0] avs_address_i,
	input  wire logic                     avs_read_i,
	input  wire logic                     avs_write_i,
	input  wire logic [pmcs_pkg::AV_DW-1:0] avs_writedata_i,
	output logic      [pmcs_pkg::AV_DW-1:0] avs_readdata_o,
	output logic                          avs_waitrequest_o,
	input  wire logic                     module_select_n_i,
	input  wire logic                     module_reset_n_i,
	input  wire logic                     low_power_request_i,
	input  wire logic                     scl_i,
	input  wire logic                     sda_i,
	output logic                          sda_o,
	output logic                          sda_oe_o,
	output logic                          interrupt_n_o,
	output logic                          interrupt_n_oe_o,
	output logic                          module_present_n_o,
	output logic                          low_power_o
);

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic [7:0] ser_byte(
		input logic [7:0]                 ptr,
		input pmcs_pkg::pmcs_state_s      st
	);
		logic [7:0] b;
		b = 8'h00;
		if (ptr == pmcs_pkg::PTR_STATUS)
			b[pmcs_pkg::BIT_NRDY] = st.not_ready;
		else if (ptr == pmcs_pkg::PTR_FLAGS)
			b[pmcs_pkg::NFLAG-1:0] = st.flags;
		else if (ptr == pmcs_pkg::PTR_MASK)
			b[pmcs_pkg::NFLAG-1:0] = st.mask;
		else if (ptr == pmcs_pkg::PTR_CTRL)
			b[pmcs_pkg::BIT_PDOWN] = st.pdown;
		return b;
	endfunction

	function automatic logic [pmcs_pkg::AV_DW-1:0] av_word(
		input logic [pmcs_pkg::AV_AW-1:0] addr,
		input pmcs_pkg::pmcs_state_s      st,
		input logic                       bus_en
	);
		logic [pmcs_pkg::AV_DW-1:0] w;
		w = 32'h0000_0000;
		if (addr == pmcs_pkg::REG_COND)
			w[pmcs_pkg::NFLAG-1:0] = st.cond;
		else if (addr == pmcs_pkg::REG_STATUS)
			w[14:0] = {st.pm, bus_en, st.lowpwr, st.pdown, st.irq,
				st.done, st.not_ready, st.mask, st.flags};
		return w;
	endfunction

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	pmcs_pkg::pmcs_pins_s pins;

	pmcs_sync #(
		.W       (pmcs_pkg::NSYNC),
		.RST_VAL (pmcs_pkg::SYNC_RST)
	) u_sync (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.d_i       ({scl_i, sda_i, module_select_n_i, module_reset_n_i,
			low_power_request_i}),
		.q_o       (pins)
	);

	// ************************************************************
	// State
	// ************************************************************
	pmcs_pkg::pmcs_state_s state_r;
	pmcs_pkg::pmcs_state_s state_nxt;

	logic                         bus_en;
	logic                         scl_rise;
	logic                         scl_fall;
	logic                         start_c;
	logic                         stop_c;
	logic                         load_rd;
	logic                         wr_stb;
	logic                         clr_done;
	logic [pmcs_pkg::NFLAG-1:0]   clr_flags;
	logic                         soft_rst;
	logic [7:0]                   rd_b;

	localparam logic [pmcs_pkg::RCNT_W-1:0] RCNT_MAX =
		pmcs_pkg::RCNT_W'(pmcs_pkg::RESET_PULSE_CYC);
	localparam logic [pmcs_pkg::CNT_W-1:0]  INIT_LAST =
		pmcs_pkg::CNT_W'(INIT_CYCLES - 1);

	// Selection is sampled every cycle, far inside 100 us either way
	assign bus_en   = ~pins.sel_n
		& (state_r.pm == pmcs_pkg::PM_RUN);
	assign scl_rise = pins.scl & ~state_r.scl_q;
	assign scl_fall = ~pins.scl & state_r.scl_q;
	assign start_c  = pins.scl & state_r.scl_q & state_r.sda_q & ~pins.sda;
	assign stop_c   = pins.scl & state_r.scl_q & ~state_r.sda_q & pins.sda;

	always_comb begin
		state_nxt = state_r;
		load_rd   = 1'b0;
		wr_stb    = 1'b0;
		clr_done  = 1'b0;
		clr_flags = '0;
		soft_rst  = 1'b0;
		rd_b      = 8'h00;

		// ********************************************************
		// Register bus: one wait cycle, then the answer
		// ********************************************************
		state_nxt.av_ack = (avs_read_i | avs_write_i) & ~state_r.av_ack;
		if (avs_read_i && !state_r.av_ack)
			state_nxt.av_rdata = av_word(avs_address_i, state_r, bus_en);
		if (avs_write_i && state_r.av_ack
			&& avs_address_i == pmcs_pkg::REG_COND)
			state_nxt.cond = avs_writedata_i[pmcs_pkg::NFLAG-1:0];

		// ********************************************************
		// Reset pin and initialisation
		// ********************************************************
		if (pins.rst_n) begin
			state_nxt.rst_cnt = '0;
		end else if (state_r.rst_cnt
			!= RCNT_MAX) begin
			state_nxt.rst_cnt = state_r.rst_cnt + 1'b1;
		end

		unique case (state_r.pm)
			pmcs_pkg::PM_RUN: begin
				state_nxt.init_cnt = '0;
			end
			pmcs_pkg::PM_BOOT: begin
				// Power-up lands here too, so completion needs no pulse
				if (state_r.init_cnt == INIT_LAST) begin
					state_nxt.pm        = pmcs_pkg::PM_RUN;
					state_nxt.not_ready = 1'b0;
					state_nxt.done      = 1'b1;
				end else begin
					state_nxt.init_cnt = state_r.init_cnt + 1'b1;
				end
			end
			pmcs_pkg::PM_HELD: begin
				if (pins.rst_n) begin
					state_nxt.pm       = pmcs_pkg::PM_BOOT;
					state_nxt.init_cnt = '0;
				end
			end
		endcase

		// A low shorter than the minimum pulse is ignored
		if (state_r.rst_cnt == RCNT_MAX && !pins.rst_n) begin
			soft_rst     = 1'b1;
			state_nxt.pm = pmcs_pkg::PM_HELD;
		end

		// ********************************************************
		// Serial management slave
		// ********************************************************
		state_nxt.scl_q = pins.scl;
		state_nxt.sda_q = pins.sda;
		if (!bus_en) begin
			state_nxt.ser       = pmcs_pkg::SER_IDLE;
			state_nxt.sda_drive = 1'b0;
		end else if (start_c) begin
			state_nxt.ser       = pmcs_pkg::SER_ADDR;
			state_nxt.bitcnt    = '0;
			state_nxt.sda_drive = 1'b0;
		end else if (stop_c) begin
			state_nxt.ser       = pmcs_pkg::SER_IDLE;
			state_nxt.sda_drive = 1'b0;
		end else begin
			unique case (state_r.ser)
				pmcs_pkg::SER_IDLE: begin
					state_nxt.sda_drive = 1'b0;
				end
				pmcs_pkg::SER_ADDR: begin
					if (scl_rise) begin
						state_nxt.shreg  = {state_r.shreg[6:0], pins.sda};
						state_nxt.bitcnt = state_r.bitcnt + 1'b1;
					end else if (scl_fall
						&& state_r.bitcnt == pmcs_pkg::BITS_BYTE) begin
						if (state_r.shreg[7:1] == pmcs_pkg::DEV_ADDR) begin
							state_nxt.ser       = pmcs_pkg::SER_ADDR_AK;
							state_nxt.sda_drive = 1'b1;
							state_nxt.rd_dir    = state_r.shreg[0];
							state_nxt.first_wr  = 1'b1;
						end else begin
							state_nxt.ser = pmcs_pkg::SER_IDLE;
						end
					end
				end
				pmcs_pkg::SER_ADDR_AK: begin
					if (scl_fall) begin
						state_nxt.bitcnt = '0;
						if (state_r.rd_dir) begin
							load_rd = 1'b1;
						end else begin
							state_nxt.sda_drive = 1'b0;
							state_nxt.ser       = pmcs_pkg::SER_WR;
						end
					end
				end
				pmcs_pkg::SER_WR: begin
					if (scl_rise) begin
						state_nxt.shreg  = {state_r.shreg[6:0], pins.sda};
						state_nxt.bitcnt = state_r.bitcnt + 1'b1;
					end else if (scl_fall
						&& state_r.bitcnt == pmcs_pkg::BITS_BYTE) begin
						state_nxt.sda_drive = 1'b1;
						state_nxt.ser       = pmcs_pkg::SER_WR_AK;
						wr_stb              = 1'b1;
					end
				end
				pmcs_pkg::SER_WR_AK: begin
					if (scl_fall) begin
						state_nxt.sda_drive = 1'b0;
						state_nxt.bitcnt    = '0;
						state_nxt.ser       = pmcs_pkg::SER_WR;
					end
				end
				pmcs_pkg::SER_RD: begin
					if (scl_fall) begin
						if (state_r.bitcnt == pmcs_pkg::LAST_BIT) begin
							state_nxt.sda_drive = 1'b0;
							state_nxt.bitcnt    = '0;
							state_nxt.ser       = pmcs_pkg::SER_RD_AK;
						end else begin
							state_nxt.sda_drive = ~state_r.shreg[6];
							state_nxt.shreg = {state_r.shreg[6:0], 1'b0};
							state_nxt.bitcnt = state_r.bitcnt + 1'b1;
						end
					end
				end
				pmcs_pkg::SER_RD_AK: begin
					if (scl_rise) begin
						state_nxt.mnack = pins.sda;
					end else if (scl_fall) begin
						if (state_r.mnack)
							state_nxt.ser = pmcs_pkg::SER_IDLE;
						else
							load_rd = 1'b1;
					end
				end
			endcase
		end

		// Byte out: reading the status byte clears done, reading the flags byte clears the flags
		if (load_rd) begin
			rd_b                = ser_byte(state_r.ptr, state_r);
			state_nxt.shreg     = rd_b;
			state_nxt.sda_drive = ~rd_b[7];
			state_nxt.ptr       = state_r.ptr + 1'b1;
			state_nxt.ser       = pmcs_pkg::SER_RD;
			if (state_r.ptr == pmcs_pkg::PTR_STATUS)
				clr_done = 1'b1;
			if (state_r.ptr == pmcs_pkg::PTR_FLAGS)
				clr_flags = state_r.flags;
		end

		// First byte after the address is the pointer
		if (wr_stb) begin
			state_nxt.first_wr = 1'b0;
			if (state_r.first_wr) begin
				state_nxt.ptr = state_r.shreg;
			end else begin
				state_nxt.ptr = state_r.ptr + 1'b1;
				if (state_r.ptr == pmcs_pkg::PTR_MASK)
					state_nxt.mask =
						state_r.shreg[pmcs_pkg::NFLAG-1:0];
				if (state_r.ptr == pmcs_pkg::PTR_CTRL)
					state_nxt.pdown =
						state_r.shreg[pmcs_pkg::BIT_PDOWN];
			end
		end

		// ********************************************************
		// Flags: a condition present in a clearing cycle wins
		// ********************************************************
		state_nxt.flags = (state_r.flags & ~clr_flags)
			| state_r.cond;
		state_nxt.done  = state_nxt.done & ~clr_done;

		if (soft_rst) begin
			state_nxt.not_ready = 1'b1;
			state_nxt.done      = 1'b0;
			state_nxt.flags     = '0;
			state_nxt.mask      = pmcs_pkg::MASK_RST;
			state_nxt.pdown     = 1'b0;
			state_nxt.ptr       = pmcs_pkg::PTR_RST;
		end

		// Status bits stay hidden from the pin until boot completes
		state_nxt.irq = (state_r.pm == pmcs_pkg::PM_RUN)
			& (state_r.done
			| (|(state_r.flags & ~state_r.mask)));
		state_nxt.lowpwr = pins.lp | state_r.pdown;
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i)
			state_r <= pmcs_pkg::STATE_RST;
		else
			state_r <= state_nxt;
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign avs_waitrequest_o  = (avs_read_i | avs_write_i) & ~state_r.av_ack;
	assign avs_readdata_o     = state_r.av_rdata;
	assign sda_o              = 1'b0;
	assign sda_oe_o           = state_r.sda_drive;
	assign interrupt_n_o      = 1'b0;
	assign interrupt_n_oe_o   = state_r.irq;
	assign module_present_n_o = 1'b0;
	assign low_power_o        = state_r.lowpwr;

endmodule

// ---- dv/pmcs_props.sv ----
`timescale 1ns/1ps
module pmcs_props #(
	parameter int unsigned INIT_CYCLES = 50
) (
	input wire logic                         clock_i,
	input wire logic                         reset_n_i,
	input wire logic [pmcs_pkg::AV_AW-1:0]   avs_address_i,
	input wire logic                         avs_read_i,
	input wire logic                         avs_write_i,
	input wire logic [pmcs_pkg::AV_DW-1:0]   avs_readdata_o,
	input wire logic                         avs_waitrequest_o,
	input wire logic                         module_select_n_i,
	input wire logic                         module_reset_n_i,
	input wire logic                         low_power_request_i,
	input wire logic                         sda_o,
	input wire logic                         sda_oe_o,
	input wire logic                         interrupt_n_o,
	input wire logic                         interrupt_n_oe_o,
	input wire logic                         module_present_n_o,
	input wire logic                         low_power_o
);
	// Margins cover the two-stage pin synchronisers
	localparam int BOOT_MAX = INIT_CYCLES + 8;
	localparam int RST_MAX  = INIT_CYCLES + 12;
	logic [8:0] lo_cnt_r;
	logic [8:0] lo_cnt_nxt;
	always_comb begin
		lo_cnt_nxt = lo_cnt_r;
		if (module_reset_n_i)
			lo_cnt_nxt = 9'h000;
		else if (lo_cnt_r != 9'h1FF)
			lo_cnt_nxt = lo_cnt_r + 9'h001;
	end
	always_ff @(posedge clock_i) begin
		if (!reset_n_i)
			lo_cnt_r <= 9'h000;
		else
			lo_cnt_r <= lo_cnt_nxt;
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	chk_present_tied: assert property (!module_present_n_o)
		else $error("present pin not low");
	chk_open_drain: assert property (!interrupt_n_o && !sda_o)
		else $error("open drain level not low");
	chk_sel_quiet: assert property (
		module_select_n_i [*8] |-> !sda_oe_o)
		else $error("serial data driven while deselected");
	chk_lp_enter: assert property (
		$rose(low_power_request_i) |-> ##[1:8] low_power_o)
		else $error("low power not entered");
	chk_boot_quiet: assert property (
		$rose(reset_n_i) |-> (!interrupt_n_oe_o && !sda_oe_o) [*8])
		else $error("active during boot");
	chk_boot_irq: assert property (
		$rose(reset_n_i) |-> ##[1:BOOT_MAX] interrupt_n_oe_o)
		else $error("no completion interrupt after power-up");
	chk_pin_reset: assert property (
		lo_cnt_r >= 9'h0D4 && !low_power_request_i
		|-> !interrupt_n_oe_o && !low_power_o)
		else $error("long reset pulse left settings");
	chk_pin_boot: assert property (
		$rose(module_reset_n_i) && lo_cnt_r >= 9'h0D4
		|-> ##[1:RST_MAX] interrupt_n_oe_o)
		else $error("no completion interrupt after pin reset");
	chk_bus_wait: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o)
		else $error("bus wait longer than one cycle");
	chk_unmapped_zero: assert property (
		avs_read_i && !avs_waitrequest_o && avs_address_i > 4'h1
		|-> avs_readdata_o == '0)
		else $error("unmapped read not zero");
	cov_sel_ack: cover property (!module_select_n_i && sda_oe_o);
	cov_irq_clear: cover property ($fell(interrupt_n_oe_o));
	cov_low_power: cover property ($rose(low_power_o));
endmodule
bind pmcs_core pmcs_props #(.INIT_CYCLES(INIT_CYCLES)) i_props (
	.clock_i(clock_i), .reset_n_i(reset_n_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o),
	.module_select_n_i(module_select_n_i),
	.module_reset_n_i(module_reset_n_i),
	.low_power_request_i(low_power_request_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .interrupt_n_o(interrupt_n_o),
	.interrupt_n_oe_o(interrupt_n_oe_o),
	.module_present_n_o(module_present_n_o), .low_power_o(low_power_o)
);

// ---- dv/pmcs_host.sv ----
`timescale 1ns/1ps
module pmcs_host (
	input  wire logic clock_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	// Low phase alternates 6 and 7 cycles: 125 ns average period
	bit odd = 1'b0;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic bit_io(input logic b, output logic r);
		cyc(3);
		sda_o <= b;
		cyc(odd ? 4 : 3);
		scl_o <= 1'b1;
		cyc(3);
		r = sda_i;
		cyc(3);
		scl_o <= 1'b0;
		odd = !odd;
	endtask
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
			output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(1'b1, ack);
	endtask
	// Also serves as repeated start when the clock is low
	task automatic start;
		cyc(3);
		sda_o <= 1'b1;
		cyc(3);
		scl_o <= 1'b1;
		cyc(6);
		sda_o <= 1'b0;
		cyc(6);
		scl_o <= 1'b0;
	endtask
	// Clock is left standing high between frames
	task automatic stop;
		cyc(3);
		sda_o <= 1'b0;
		cyc(3);
		scl_o <= 1'b1;
		cyc(6);
		sda_o <= 1'b1;
		cyc(6);
	endtask
	// Flag state is learned by reads like this one, or from the status register over the register bus
	task automatic xfer(input logic rd, input logic [7:0] ptr,
			input logic [7:0] wd, output logic [7:0] q, output logic ok);
		logic [7:0] junk;
		logic       a0;
		logic       a1;
		logic       a2;
		q = 8'hFF;
		start();
		byte_io({pmcs_pkg::DEV_ADDR, 1'b0}, junk, a0);
		byte_io(ptr, junk, a1);
		if (rd) begin
			start();
			byte_io({pmcs_pkg::DEV_ADDR, 1'b1}, junk, a2);
			byte_io(8'hFF, q, junk[0]);
		end else begin
			byte_io(wd, junk, a2);
		end
		stop();
		ok = !a0 && !a1 && !a2;
	endtask
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	localparam int INIT = 50;
	logic                         clock_i = 1'b0;
	logic                         reset_n_i = 1'b0;
	logic [pmcs_pkg::AV_AW-1:0]   av_addr = '0;
	logic                         av_rd = 1'b0;
	logic                         av_wr = 1'b0;
	logic [31:0]                  av_wdata = '0;
	logic [31:0]                  av_rdata;
	logic                         av_wait;
	logic                         sel_n = 1'b0;
	logic                         mrst_n = 1'b1;
	logic                         lp = 1'b0;
	logic                         scl;
	logic                         host_sda;
	logic                         dut_sda;
	logic                         sda_oe;
	logic                         sda_w;
	logic                         irq_n;
	logic                         irq_oe;
	logic                         pres_n;
	logic                         lowp;
	int                           errors = 0;
	int                           checked = 0;
	int                           cycles = 0;
	assign sda_w = host_sda & (sda_oe ? dut_sda : 1'b1);
	always #5 clock_i = ~clock_i;
	pmcs_core #(.INIT_CYCLES(INIT)) i_dut (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .avs_address_i(av_addr),
		.avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wdata),
		.avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait),
		.module_select_n_i(sel_n), .module_reset_n_i(mrst_n),
		.low_power_request_i(lp), .scl_i(scl), .sda_i(sda_w),
		.sda_o(dut_sda), .sda_oe_o(sda_oe), .interrupt_n_o(irq_n),
		.interrupt_n_oe_o(irq_oe), .module_present_n_o(pres_n),
		.low_power_o(lowp)
	);
	pmcs_host i_host (
		.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda)
	);
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors++;
			$display("[ERR] %0t timeout", $time);
			conclude();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic av(input logic w, input logic [pmcs_pkg::AV_AW-1:0] a,
			input logic [31:0] d, output logic [31:0] q);
		@(posedge clock_i);
		av_addr <= a;
		av_wdata <= d;
		av_wr <= w;
		av_rd <= !w;
		@(posedge clock_i);
		while (av_wait !== 1'b0)
			@(posedge clock_i);
		q = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask
	task automatic wait_irq(input logic lvl, input int n);
		repeat (n) begin
			@(posedge clock_i);
			if (irq_oe === lvl)
				break;
		end
		cmp(irq_oe, lvl);
	endtask
	task automatic i2c(input logic rd, input logic [7:0] p,
			input logic [7:0] d, output logic [7:0] q);
		logic ok;
		i_host.xfer(rd, p, d, q, ok);
		cmp(ok, 1'b1);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_powerup;
		logic [7:0] b;
		cmp(pres_n, 1'b0);
		wait_irq(1'b1, INIT + 20);
		i2c(1'b1, pmcs_pkg::PTR_STATUS, 8'h00, b);
		cmp(b[pmcs_pkg::BIT_NRDY], 1'b0);
		wait_irq(1'b0, 20);
		$display("powerup end");
	endtask
	task automatic t_select;
		logic [7:0] b;
		logic       ok;
		@(posedge clock_i);
		sel_n <= 1'b1;
		repeat (20) @(posedge clock_i);
		i_host.xfer(1'b0, pmcs_pkg::PTR_MASK, 8'h00, b, ok);
		cmp(ok, 1'b0);
		sel_n <= 1'b0;
		repeat (20) @(posedge clock_i);
		i2c(1'b0, pmcs_pkg::PTR_MASK, 8'h00, b);
		$display("select end");
	endtask
	task automatic t_flags;
		logic [31:0] q;
		logic [7:0]  b;
		for (int i = 0; i < pmcs_pkg::NFLAG; i++) begin
			av(1'b1, pmcs_pkg::REG_COND, 32'h1 << i, q);
			wait_irq(1'b1, 40);
			av(1'b1, pmcs_pkg::REG_COND, 32'h0, q);
			i2c(1'b1, pmcs_pkg::PTR_FLAGS, 8'h00, b);
			cmp(b, 8'h01 << i);
			wait_irq(1'b0, 40);
		end
		av(1'b0, 4'h7, 32'h0, q);
		cmp(q, 32'h0);
		$display("flags end");
	endtask
	task automatic t_mask;
		logic [31:0] q;
		logic [7:0]  b;
		i2c(1'b0, pmcs_pkg::PTR_MASK, 8'h01, b);
		av(1'b1, pmcs_pkg::REG_COND, 32'h1, q);
		repeat (40) @(posedge clock_i);
		cmp(irq_oe, 1'b0);
		av(1'b0, pmcs_pkg::REG_STATUS, 32'h0, q);
		cmp(q[pmcs_pkg::FLAG_RX_LOS], 1'b1);
		i2c(1'b0, pmcs_pkg::PTR_MASK, 8'h00, b);
		wait_irq(1'b1, 40);
		av(1'b1, pmcs_pkg::REG_COND, 32'h0, q);
		i2c(1'b1, pmcs_pkg::PTR_FLAGS, 8'h00, b);
		wait_irq(1'b0, 40);
		$display("mask end");
	endtask
	task automatic t_power;
		logic [7:0] b;
		@(posedge clock_i);
		lp <= 1'b1;
		repeat (8) @(posedge clock_i);
		cmp(lowp, 1'b1);
		lp <= 1'b0;
		repeat (8) @(posedge clock_i);
		cmp(lowp, 1'b0);
		i2c(1'b0, pmcs_pkg::PTR_CTRL, 8'h01, b);
		repeat (10) @(posedge clock_i);
		cmp(lowp, 1'b1);
		i2c(1'b0, pmcs_pkg::PTR_CTRL, 8'h00, b);
		repeat (10) @(posedge clock_i);
		cmp(lowp, 1'b0);
		$display("power end");
	endtask
	task automatic t_pin_reset;
		logic [7:0] b;
		i2c(1'b0, pmcs_pkg::PTR_MASK, 8'h07, b);
		i2c(1'b0, pmcs_pkg::PTR_CTRL, 8'h01, b);
		@(posedge clock_i);
		mrst_n <= 1'b0;
		repeat (150) @(posedge clock_i);
		mrst_n <= 1'b1;
		repeat (10) @(posedge clock_i);
		i2c(1'b1, pmcs_pkg::PTR_MASK, 8'h00, b);
		cmp(b, 8'h07);
		@(posedge clock_i);
		mrst_n <= 1'b0;
		// Held past the 2 us minimum
		repeat (212) @(posedge clock_i);
		cmp({irq_oe, lowp}, 2'h0);
		mrst_n <= 1'b1;
		wait_irq(1'b1, INIT + 30);
		i2c(1'b1, pmcs_pkg::PTR_MASK, 8'h00, b);
		cmp(b, 8'h00);
		$display("pin reset end");
	endtask
	initial begin
		repeat (4) @(posedge clock_i);
		reset_n_i <= 1'b1;
		t_powerup();
		t_select();
		t_flags();
		t_mask();
		t_power();
		t_pin_reset();
		conclude();
	end
endmodule
